// File: rtl/ccp_map.vh
// Purpose: Register map, field positions and reset values for the channel value high byte
//          and timer-select block.
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register.
// Notes:   Eight-bit registers sit in the low byte; upper bits read as zero.
`ifndef CCP_MAP_VH
`define CCP_MAP_VH

// Word offsets (byte addresses)
`define OFS_VALUE_HIGH_BASE  6'h00
`define OFS_CHAN_CTRL_BASE   6'h14
`define OFS_TSEL_A           6'h28
`define OFS_TSEL_B           6'h2C
`define NUM_CHAN             5

// Per-channel control word fields
`define CTRL_MODE_MSB        3
`define CTRL_MODE_LSB        0
`define CTRL_ALIGN_BIT       4

// Reset values
`define RST_VALUE_HIGH       8'h00
`define RST_CHAN_CTRL        5'h00
`define RST_TSEL_A           8'h55
`define RST_TSEL_B           6'h15

// Timer-select field positions in the second select register
`define TSELB_CHAN5_LSB      0
`define TSELB_PWM6_LSB       2
`define TSELB_PWM7_LSB       4

// Mode codes
`define MODE_OFF             4'h0
`define MODE_CMP_TGL_CLR     4'h1
`define MODE_CMP_TGL         4'h2
`define MODE_CAP_FIRST       4'h3
`define MODE_CAP_LAST        4'h7
`define MODE_CMP_FIRST       4'h8
`define MODE_CMP_LAST        4'hB
`define MODE_PWM             4'hF

// Timer-select codes
`define TSEL_RESERVED        2'h0
`define TSEL_BASE_LOW        2'h1
`define TSEL_BASE_MID        2'h2
`define TSEL_BASE_HIGH       2'h3

`endif

// File: rtl/ccp_chan_high.v
// Purpose: One channel: value high byte, capture load, compare match and PWM width bits.
// Assumes: Timer inputs and events are synchronous to clk.
// Notes:   Software write and capture on the same edge: capture wins.
`timescale 1ns/1ps
`include "ccp_map.vh"

module ccp_chan_high (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] mode,
  input  wire       align,
  input  wire [1:0] tsel,
  input  wire [7:0] sixteen_bit_timer_one_hi,
  input  wire [7:0] sixteen_bit_timer_three_hi,
  input  wire [7:0] sixteen_bit_timer_five_hi,
  input  wire       capture_evt,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] value_r,
  output reg        match_hi_r,
  output reg  [7:0] width_hi_r,
  output reg  [2:0] cc_sel_r,
  output reg  [2:0] pwm_sel_r
);

  // Code to one-hot time base; reserved code selects nothing
  function [2:0] tsel_onehot;
    input [1:0] code;
    begin
      case (code)
        `TSEL_BASE_LOW:  tsel_onehot = 3'h1;
        `TSEL_BASE_MID:  tsel_onehot = 3'h2;
        `TSEL_BASE_HIGH: tsel_onehot = 3'h4;
        default:         tsel_onehot = 3'h0;
      endcase
    end
  endfunction

  wire       is_pwm = (mode == `MODE_PWM);
  wire       is_cap = (mode >= `MODE_CAP_FIRST) && (mode <= `MODE_CAP_LAST);
  wire       is_cmp = (mode == `MODE_CMP_TGL_CLR) || (mode == `MODE_CMP_TGL) ||
                      ((mode >= `MODE_CMP_FIRST) && (mode <= `MODE_CMP_LAST));
  wire [2:0] sel    = tsel_onehot(tsel);
  reg  [7:0] tmr_hi;

  // Selected 16-bit timer high byte; reserved code reads as zero
  always @* begin
    case (sel)
      3'h1:    tmr_hi = sixteen_bit_timer_one_hi;
      3'h2:    tmr_hi = sixteen_bit_timer_three_hi;
      3'h4:    tmr_hi = sixteen_bit_timer_five_hi;
      default: tmr_hi = 8'h00;
    endcase
  end

  // Value byte: capture loads the timer high byte, else software write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      value_r <= `RST_VALUE_HIGH;
    end else if (is_cap && capture_evt && (sel != 3'h0)) begin
      value_r <= tmr_hi;
    end else if (wr_en) begin
      value_r <= wr_data;
    end
  end

  // Outputs are quiet when the channel is off or the mode does not use them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      match_hi_r <= 1'b0;
      width_hi_r <= 8'h00;
      cc_sel_r   <= 3'h0;
      pwm_sel_r  <= 3'h0;
    end else begin
      match_hi_r <= is_cmp && (sel != 3'h0) && (value_r == tmr_hi);
      if (!is_pwm) begin
        width_hi_r <= 8'h00;
      end else if (align) begin
        width_hi_r <= value_r;
      end else begin
        width_hi_r <= {6'h00, value_r[1:0]};
      end
      cc_sel_r  <= (is_cap || is_cmp) ? sel : 3'h0;
      pwm_sel_r <= is_pwm ? sel : 3'h0;
    end
  end

endmodule

// File: rtl/ccp_high_tsel.v
// Purpose: Value high bytes of five capture/compare/PWM channels and the timer-select
//          registers for them and for two standalone PWM channels, on Avalon-MM.
// Assumes: Single clock; timers and capture events synchronous to clk.
// Notes:   Each access is answered one cycle after the request is seen.
//          Writes need the low byte lane; other lanes carry nothing here.
//          A reserved select code leaves the channel without a time base.
//          Mode off silences a channel's outputs but keeps its value byte.
//          Readdata stands until the next read completes.
// Functional notes
// - Capture loads high byte from selected timer
// - Compare uses high byte as upper byte
// - Right-aligned PWM uses bits 1:0 only
// - Left-aligned PWM uses all eight bits
// - Two-bit select picks channel time base
// - First select register holds channels four..one
// - Second holds chan5, PWM6, PWM7; 7:6 zero
// - Standalone PWM select picks timer six/four/two
// - Mode field selects off, capture, compare, PWM
// - Alignment bit set means left-aligned, PWM only
`timescale 1ns/1ps
`include "ccp_map.vh"

module ccp_high_tsel (
  input  wire        clk,
  input  wire        rst,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire [15:0] sixteen_bit_timer_one,
  input  wire [15:0] sixteen_bit_timer_three,
  input  wire [15:0] sixteen_bit_timer_five,
  input  wire [4:0]  capture_event,
  output wire [4:0]  compare_match_hi,
  output wire [39:0] pwm_width_msb,
  output wire [14:0] cc_timer_sel,
  output wire [14:0] pwm_timer_sel,
  output reg  [2:0]  pwm_six_timer_sel,
  output reg  [2:0]  pwm_seven_timer_sel
);

  // Register map, one word per register with its data in the low byte: the value
  // high bytes of channels one to five, their control words, then the two select
  // registers. Unmapped words read zero and ignore writes.

  // Standalone PWM select code to one-hot {six, four, two}
  // The reserved code decodes to no timer rather than a guess at one
  function [2:0] pwm_base;
    input [1:0] code;
    begin
      case (code)
        `TSEL_BASE_LOW:  pwm_base = 3'h1;
        `TSEL_BASE_MID:  pwm_base = 3'h2;
        `TSEL_BASE_HIGH: pwm_base = 3'h4;
        default:         pwm_base = 3'h0;
      endcase
    end
  endfunction

  // Byte address of word idx of a register group; cut to the bus width on purpose
  function [5:0] word_ofs;
    input [5:0]   base;
    input integer idx;
    reg   [31:0]  full;
    begin
      full     = base + (idx * 4);
      word_ofs = full[5:0];
    end
  endfunction

  reg         ack_r;
  reg  [7:0]  tsel_a_r;
  reg  [5:0]  tsel_b_r;
  reg  [7:0]  tsel_a_nxt;
  reg  [5:0]  tsel_b_nxt;
  reg  [4:0]  ctrl_r [0:`NUM_CHAN-1];
  wire [39:0] value_bus;
  wire [9:0]  chan_tsel;

  // Address hits shared by the write side and the read mux
  wire        hit_tsel_a = (address == `OFS_TSEL_A);
  wire        hit_tsel_b = (address == `OFS_TSEL_B);

  // A write lands only on the completing edge, so a request held through its wait state writes once;
  // a write with byteenable[0] low is answered but changes nothing
  wire        wr_go      = ack_r && write && byteenable[0];

  // One-cycle answer; waitrequest drops once the request has been held a cycle
  assign waitrequest = (read || write) && !ack_r;

  // ack_r clears itself after one cycle, so a request still held after its
  // completing edge is taken as a fresh access with its own wait state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read || write) && !ack_r;
    end
  end

  // Select fields per channel: four in the first register, channel five in the second
  // Field n sits at bits 2n+1:2n of this vector, so all five channels index alike
  assign chan_tsel = {tsel_b_r[`TSELB_CHAN5_LSB+1:`TSELB_CHAN5_LSB], tsel_a_r};

  // Next select values; bits above each register's width are dropped
  // Channel select outputs follow one edge after these registers change
  always @* begin
    tsel_a_nxt = tsel_a_r;
    tsel_b_nxt = tsel_b_r;
    if (wr_go && hit_tsel_a) begin
      tsel_a_nxt = writedata[7:0];
    end
    if (wr_go && hit_tsel_b) begin
      tsel_b_nxt = writedata[5:0];
    end
  end

  // Timer-select registers; reset puts every field on its lowest base code
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tsel_a_r <= `RST_TSEL_A;
      tsel_b_r <= `RST_TSEL_B;
    end else begin
      tsel_a_r <= tsel_a_nxt;
      tsel_b_r <= tsel_b_nxt;
    end
  end

  // Standalone PWM time bases, registered
  // One edge of delay keeps these aligned with the channel select outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_six_timer_sel   <= 3'h0;
      pwm_seven_timer_sel <= 3'h0;
    end else begin
      pwm_six_timer_sel   <= pwm_base(tsel_b_r[`TSELB_PWM6_LSB+1:`TSELB_PWM6_LSB]);
      pwm_seven_timer_sel <= pwm_base(tsel_b_r[`TSELB_PWM7_LSB+1:`TSELB_PWM7_LSB]);
    end
  end

  // One instance per channel. A capture and a software write to the same value
  // byte in one cycle keep the captured byte; the write is answered but lost.
  wire [4:0]  value_wr;
  genvar      g;
  generate
    for (g = 0; g < `NUM_CHAN; g = g + 1) begin : chan
      // Offsets of this channel's value and control words
      wire [5:0] val_ofs  = word_ofs(`OFS_VALUE_HIGH_BASE, g);
      wire [5:0] ctrl_ofs = word_ofs(`OFS_CHAN_CTRL_BASE, g);

      assign value_wr[g] = wr_go && (address == val_ofs);

      // Mode and alignment per channel; bits above the align bit are ignored
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ctrl_r[g] <= `RST_CHAN_CTRL;
        end else if (wr_go && (address == ctrl_ofs)) begin
          ctrl_r[g] <= writedata[4:0];
        end
      end

      // Value byte, match, pulse width and select outputs of this channel
      ccp_chan_high u_chan (
        .clk         (clk),
        .rst         (rst),
        .mode        (ctrl_r[g][`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
        .align       (ctrl_r[g][`CTRL_ALIGN_BIT]),
        .tsel        (chan_tsel[2*g+1:2*g]),
        .sixteen_bit_timer_one_hi     (sixteen_bit_timer_one[15:8]),
        .sixteen_bit_timer_three_hi     (sixteen_bit_timer_three[15:8]),
        .sixteen_bit_timer_five_hi     (sixteen_bit_timer_five[15:8]),
        .capture_evt (capture_event[g]),
        .wr_en       (value_wr[g]),
        .wr_data     (writedata[7:0]),
        .value_r     (value_bus[8*g+7:8*g]),
        .match_hi_r  (compare_match_hi[g]),
        .width_hi_r  (pwm_width_msb[8*g+7:8*g]),
        .cc_sel_r    (cc_timer_sel[3*g+2:3*g]),
        .pwm_sel_r   (pwm_timer_sel[3*g+2:3*g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero. Captured values are live block state.
  reg [31:0] rd_nxt;
  integer    i;
  always @* begin
    rd_nxt = 32'h0000_0000;
    // The register groups never overlap, so at most one branch hits
    if (hit_tsel_a) begin
      rd_nxt = {24'h000000, tsel_a_r};
    end
    if (hit_tsel_b) begin
      rd_nxt = {26'h0000000, tsel_b_r};
    end
    for (i = 0; i < `NUM_CHAN; i = i + 1) begin
      if (address == word_ofs(`OFS_VALUE_HIGH_BASE, i)) begin
        rd_nxt = {24'h000000, value_bus[8*i +: 8]};
      end
      if (address == word_ofs(`OFS_CHAN_CTRL_BASE, i)) begin
        rd_nxt = {27'h0000000, ctrl_r[i]};
      end
    end
  end

  // Read data stands from the answering edge until the next read answer
  // Loaded in the wait cycle so that it is settled when waitrequest drops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (!ack_r && read) begin
      readdata <= rd_nxt;
    end
  end

endmodule

// File: bench/ccp_high_tsel_checker.sv
// Purpose: Bus handshake and select-output checks for ccp_high_tsel.
// Assumes: Master holds each request until waitrequest is seen low.
// Notes:   One-hot selects guard against two timers feeding one channel.
`timescale 1ns/1ps
module ccp_high_tsel_checker (
  input wire        clk,
  input wire        rst,
  input wire [5:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire [14:0] cc_timer_sel,
  input wire [14:0] pwm_timer_sel,
  input wire [39:0] pwm_width_msb,
  input wire [2:0]  pwm_six_timer_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A fresh request always waits once, then completes
  wait_first_a: assert property ($rose(read | write) |-> waitrequest)
    else $error("new request not held off");
  one_wait_a: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  idle_free_a: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest without request");
  rd_upper_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Read data only moves on a read
  rd_hold_a: assert property (!read |=> $stable(readdata))
    else $error("readdata moved without read");
  tselb_top_a: assert property (read && !waitrequest && address == 6'h2C |-> readdata[7:6] == 2'h0)
    else $error("second select top bits not zero");
  mode_excl_a: assert property (pwm_width_msb[23:16] != 8'h00 |->
    cc_timer_sel[8:6] == 3'h0)
    else $error("width and capture select together");
  sel_hot_a: assert property ($onehot0(pwm_six_timer_sel) && $onehot0(pwm_timer_sel[2:0]) && $onehot0(cc_timer_sel[2:0]))
    else $error("timer select not one-hot");
endmodule
bind ccp_high_tsel ccp_high_tsel_checker u_ccp_high_tsel_checker (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .cc_timer_sel(cc_timer_sel), .pwm_timer_sel(pwm_timer_sel),
  .pwm_width_msb(pwm_width_msb), .pwm_six_timer_sel(pwm_six_timer_sel));

// File: bench/timer_model.sv
// Purpose: Timer counts feeding the channels.
// Assumes: High bytes held per test.
// Notes:   Low byte runs so a wrong byte choice shows.
`timescale 1ns/1ps
module timer_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  base_hi,
  output wire [15:0] t1,
  output wire [15:0] t3,
  output wire [15:0] t5
);
  reg [7:0] lo_r;
  // Free-running low byte
  always @(posedge clk or posedge rst)
    if (rst) lo_r <= 8'h00;
    else lo_r <= lo_r + 8'h01;
  assign t1 = {base_hi, lo_r};
  assign t3 = {base_hi + 8'h11, lo_r};
  assign t5 = {base_hi + 8'h22, lo_r};
endmodule

// File: bench/ccp_high_tsel_tb.sv
// Purpose: Register-level tests of ccp_high_tsel.
// Assumes: Outputs settle within three edges of a write.
// Notes:   Full byte lanes only.
`timescale 1ns/1ps
module ccp_high_tsel_tb;
  reg         clk = 1'h0;
  reg         rst = 1'h1;
  reg  [5:0]  address = 6'h00;
  reg         read = 1'h0;
  reg         write = 1'h0;
  reg  [31:0] writedata = 32'h0;
  reg  [4:0]  capture_event = 5'h00;
  reg  [7:0]  base_hi = 8'h40;
  reg  [7:0]  rv;
  wire [31:0] readdata;
  wire        waitrequest;
  wire [15:0] t1, t3, t5;
  wire [4:0]  match;
  wire [39:0] width;
  wire [14:0] cc_sel, pwm_sel;
  wire [2:0]  p6_sel, p7_sel;
  integer     miscompares = 0, n_checks = 0, cyc = 0, i, c;
  timer_model u_timer_model (.clk(clk), .rst(rst), .base_hi(base_hi), .t1(t1), .t3(t3),
    .t5(t5));
  ccp_high_tsel u_ccp_high_tsel (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .sixteen_bit_timer_one(t1), .sixteen_bit_timer_three(t3),
    .sixteen_bit_timer_five(t5), .capture_event(capture_event), .compare_match_hi(match),
    .pwm_width_msb(width), .cc_timer_sel(cc_sel), .pwm_timer_sel(pwm_sel),
    .pwm_six_timer_sel(p6_sel), .pwm_seven_timer_sel(p7_sel));
  always #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  task conclude; begin
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  task chk(input [31:0] seen, input [31:0] exp); begin
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  end endtask
  // One bus access; held until waitrequest is sampled low
  task acc(input w, input [5:0] a, input [7:0] d); begin
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= w;
    read <= ~w;
    @(posedge clk);
    while (waitrequest !== 1'h0) @(posedge clk);
    rv = readdata[7:0];
    write <= 1'h0;
    read <= 1'h0;
  end endtask
  task settle; repeat (3) @(posedge clk); endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    acc(0, 6'h28, 0); chk(rv, 8'h55);
    acc(0, 6'h2C, 0); chk(rv, 8'h15);
    acc(1, 6'h2C, 8'hFF); acc(0, 6'h2C, 0); chk(rv, 8'h3F);
    acc(0, 6'h30, 0); chk(rv, 8'h00);
    for (c = 0; c < 4; c = c + 1) begin
      acc(1, 6'h2C, {2'h0, c[1:0], c[1:0], 2'h1});
      settle;
      chk({p7_sel, p6_sel}, c ? {2{3'h1 << (c - 1)}} : 6'h0);
    end
    $display("test map done");
    for (i = 0; i < 5; i = i + 1)
      for (c = 1; c < 4; c = c + 1) begin
        acc(1, i < 4 ? 6'h28 : 6'h2C, i < 4 ? (8'h55 & ~(8'h3 << 2 * i)) | (c << 2 * i) : 8'h14 | c);
        acc(1, 6'h14 + 4 * i, 8'h08); settle; chk(cc_sel[3 * i +: 3], 3'h1 << (c - 1));
        acc(1, 6'h14 + 4 * i, 8'h0F); settle; chk(pwm_sel[3 * i +: 3], 3'h1 << (c - 1));
        acc(1, 6'h14 + 4 * i, 8'h00); settle; chk(cc_sel[3 * i +: 3], 3'h0);
      end
    $display("test select done");
    for (c = 1; c < 15; c = c + 1) begin
      acc(1, 6'h14, c[7:0]); settle;
      chk({pwm_sel[2:0], cc_sel[2:0]}, c < 12 ? 6'h01 : 6'h00);
    end
    $display("test modes done");
    acc(1, 6'h14, 8'h03);
    for (c = 1; c < 4; c = c + 1) begin
      acc(1, 6'h28, 8'hD4 | c[1:0]);
      @(posedge clk) capture_event <= 5'h01;
      @(posedge clk) capture_event <= 5'h00;
      acc(0, 6'h00, 0); chk(rv, 8'h40 + 8'h11 * (c - 1));
    end
    $display("test capture done");
    acc(1, 6'h28, 8'h59); acc(1, 6'h18, 8'h08); acc(1, 6'h04, 8'h51);
    settle; chk(match[1], 1'h1);
    acc(1, 6'h04, 8'h52); settle; chk(match[1], 1'h0);
    $display("test compare done");
    acc(1, 6'h08, 8'hB6); acc(1, 6'h1C, 8'h0F); settle; chk(width[23:16], 8'h02);
    acc(1, 6'h1C, 8'h1F); settle; chk(width[23:16], 8'hB6);
    acc(1, 6'h1C, 8'h18); settle; chk(width[23:16], 8'h00);
    $display("test pwm done");
    conclude;
  end
endmodule
